/* File: inc/csib_pkg.sv */
// Constants, types and helper functions of the clocked serial channel
// Operation
// - Four-bit length code: 0-7 give 8 to 15 bits, top bit set gives 16.
// - Short words sit in the low bits of transmit and receive registers.
// - Unused upper bits of a received short word read as zero.
// - Communicating flag sets on transmit write or receive dummy read.
// - Communicating flag clears at the last serial clock edge of the word.
// - Communicating flag is read-only; other status bits are read/write.
// - Overrun sets when a reception completes before the last word was read.
// - Writing 0 clears overrun; writing 1 leaves it unchanged.
// - Status reads 00H after reset and whenever channel power is off.
// - Two requests: reception complete (higher) and transmission enable.
// - Reception complete fires on receive register load, and on overrun in single mode or with receive enabled.
// - In single mode reception complete fires after every transfer.
// - Transmission enable fires only in continuous transmit modes.
// - Master transmit: transmit write sets the flag and starts shifting.
// - Master drives the serial clock and shifts data out with it.
// - After the word: clock and data stop, flag clears; interrupt fires in single mode or with receive enabled.
// - Master receive: dummy read starts reception sampling data in.
// - Receive read with start trigger enabled starts the next reception.
// - Clock code: 0-5 divide by 2 to 64, 6 baud generator, 7 slave.
// - Data out low without transmit enable; no receive update without receive enable.
package csib_pkg;
   // ***************************************************************
   // Register indices, byte address is four times the index
   // ***************************************************************
   localparam logic [29:0] IDX_MAIN = 30'h0ffffd00;
   localparam logic [29:0] IDX_CLKMODE = 30'h0ffffd01;
   localparam logic [29:0] IDX_LENGTH = 30'h0ffffd02;
   localparam logic [29:0] IDX_STATUS = 30'h0ffffd03;
   localparam logic [29:0] IDX_TX = 30'h0ffffd04;
   localparam logic [29:0] IDX_RX = 30'h0ffffd06;
   // ***************************************************************
   // Field positions, masks and reset values
   // ***************************************************************
   localparam int MC_PWR = 7;
   localparam int MC_TXE = 6;
   localparam int MC_RXE = 5;
   localparam int MC_DIR = 4;
   localparam int MC_TMS = 1;
   localparam int MC_SCE = 0;
   localparam int CM_CKP = 4;
   localparam int CM_DAP = 3;
   localparam int ST_TSF = 7;
   localparam int ST_OVE = 0;
   localparam logic [7:0] MC_MASK = 8'hf3;
   localparam logic [7:0] MC_LIVE = 8'h81;
   localparam logic [7:0] CM_MASK = 8'h1f;
   localparam logic [7:0] LEN_MASK = 8'h0f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] CKS_BAUD = 3'h6;
   localparam logic [2:0] CKS_EXT = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} xfer_state_t;
   // ***************************************************************
   // Word length helpers
   // ***************************************************************
   function automatic logic [4:0] len_bits(input logic [3:0] code);
      return code[3] ? 5'h10 : {2'b01, code[2:0]};
   endfunction
   function automatic logic [15:0] len_mask(input logic [3:0] code);
      logic [16:0] m;
      m = (17'h1 << len_bits(code)) - 17'h1;
      return m[15:0];
   endfunction
   function automatic logic [15:0] top_bit(input logic [3:0] code);
      return 16'h1 << (len_bits(code) - 5'h1);
   endfunction
   function automatic logic msb_of(input logic [15:0] sh, input logic [3:0] code, input logic dir);
      return dir ? sh[0] : |(sh & top_bit(code));
   endfunction
   function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic b, input logic [3:0] code,
                                            input logic dir);
      logic [15:0] t;
      t = {sh[14:0], b};
      if (dir) begin
         t = (sh >> 1) & ~top_bit(code);
         if (b) begin
            t = t | top_bit(code);
         end
      end
      return t;
   endfunction
endpackage

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser for the serial clock and data input pins
`timescale 1ns/1ps
module pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [1:0] pins,
   output logic [1:0] synced
);
   logic [1:0] stage1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= 2'h0;
         synced <= 2'h0;
      end else if (ce) begin
         stage1 <= pins;
         synced <= stage1;
      end
   end
endmodule

/* File: hdl/half_tick_div.sv */
// Half-period tick generator for the master serial clock
`timescale 1ns/1ps
module half_tick_div (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic [2:0] clock_source,
   input wire logic baud_tick,
   output logic half_tick
);
   import csib_pkg::*;
   logic [4:0] count;
   logic [4:0] limit;
   // Divide by 2 to 64: half period of 1 to 32 clocks
   assign limit = 5'((6'h1 << clock_source) - 6'h1);
   assign half_tick = run & ((clock_source == CKS_BAUD) ? baud_tick : (count == limit));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 5'h0;
      end else if (ce) begin
         if (!run || count == limit) begin
            count <= 5'h0;
         end else begin
            count <= count + 5'h1;
         end
      end
   end
endmodule

/* File: hdl/clocked_serial_channel.sv */
// Clocked serial channel with AXI4-Lite registers, single transfer engine
`timescale 1ns/1ps
module clocked_serial_channel (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic baud_generator_output,
   input wire logic serial_clock_in,
   output logic serial_clock_out,
   output logic serial_clock_oe_n,
   output logic serial_data_out_pin,
   input wire logic serial_data_in_pin,
   output logic reception_complete_irq,
   output logic transmission_enable_irq
);
   import csib_pkg::*;

   // ***************************************************************
   // Registers and decoded fields
   // ***************************************************************
   logic [7:0] main_control_reg;
   logic [7:0] clock_mode_reg;
   logic [7:0] word_length_control;
   logic [15:0] transmit_register;
   logic [15:0] receive_register;
   logic [15:0] next_tx;
   logic overrun_flag;
   logic rx_unread;
   xfer_state_t xfer_state;
   logic [15:0] shifter;
   logic [4:0] bits_done;
   logic sck_level;
   logic sck_prev;
   logic out_bit;
   logic held_rx;
   logic pwr, txe, rxe, dir, tms, sce, dap, slave, sck_idle, tsf;
   logic [3:0] code;
   logic [1:0] synced;
   logic sck_s, din_s;

   assign pwr = main_control_reg[MC_PWR];
   assign txe = main_control_reg[MC_TXE];
   assign rxe = main_control_reg[MC_RXE];
   assign dir = main_control_reg[MC_DIR];
   assign tms = main_control_reg[MC_TMS];
   assign sce = main_control_reg[MC_SCE];
   assign dap = clock_mode_reg[CM_DAP];
   assign sck_idle = ~clock_mode_reg[CM_CKP];
   assign slave = (clock_mode_reg[2:0] == CKS_EXT);
   assign code = word_length_control[3:0];
   assign tsf = (xfer_state == ST_RUN);
   assign sck_s = synced[1];
   assign din_s = synced[0];

   // ***************************************************************
   // AXI4-Lite slave
   // ***************************************************************
   logic aw_held, w_held, wr_fire, rd_fire;
   logic [29:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_main, wr_clk, wr_len, wr_status, wr_tx, rd_rx;
   logic [31:0] read_mux;

   function automatic logic is_mapped(input logic [29:0] idx);
      return idx == IDX_MAIN || idx == IDX_CLKMODE || idx == IDX_LENGTH || idx == IDX_STATUS
             || idx == IDX_TX || idx == IDX_RX;
   endfunction

   assign awready = ce & ~aw_held & ~bvalid;
   assign wready = ce & ~w_held & ~bvalid;
   assign arready = ce & ~rvalid;
   assign wr_fire = ce & aw_held & w_held & ~bvalid;
   assign rd_fire = arvalid & arready;
   assign wr_main = wr_fire & (aw_idx == IDX_MAIN) & w_strb[0];
   assign wr_clk = wr_fire & (aw_idx == IDX_CLKMODE) & w_strb[0];
   assign wr_len = wr_fire & (aw_idx == IDX_LENGTH) & w_strb[0];
   assign wr_status = wr_fire & (aw_idx == IDX_STATUS) & w_strb[0];
   assign wr_tx = wr_fire & (aw_idx == IDX_TX) & (|w_strb[1:0]);
   assign rd_rx = rd_fire & (araddr[31:2] == IDX_RX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 30'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_idx <= awaddr[31:2];
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      case (araddr[31:2])
         IDX_MAIN: read_mux = {24'h0, main_control_reg};
         IDX_CLKMODE: read_mux = {24'h0, clock_mode_reg};
         IDX_LENGTH: read_mux = {24'h0, word_length_control};
         IDX_STATUS: read_mux = {24'h0, tsf, 6'h0, overrun_flag};
         IDX_TX: read_mux = {16'h0, transmit_register};
         IDX_RX: read_mux = {16'h0, receive_register};
         default: read_mux = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid <= 1'b1;
            rdata <= read_mux;
            rresp <= is_mapped(araddr[31:2]) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_control_reg <= REG_RESET;
      end else if (ce && wr_main) begin
         // Modes change only from power off or while switching power off
         if (!pwr || !w_data[MC_PWR]) begin
            main_control_reg <= w_data[7:0] & MC_MASK;
         end else begin
            main_control_reg <= (main_control_reg & ~MC_LIVE) | (w_data[7:0] & MC_LIVE);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_mode_reg <= REG_RESET;
      end else if (ce && wr_clk && !pwr) begin
         clock_mode_reg <= w_data[7:0] & CM_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_length_control <= REG_RESET;
      end else if (ce && wr_len && (!pwr || (!txe && !rxe))) begin
         word_length_control <= w_data[7:0] & LEN_MASK;
      end
   end

   always_comb begin
      next_tx = transmit_register;
      if (wr_tx && w_strb[0]) begin
         next_tx[7:0] = w_data[7:0];
      end
      if (wr_tx && w_strb[1]) begin
         next_tx[15:8] = w_data[15:8];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transmit_register <= 16'h0;
      end else if (ce) begin
         transmit_register <= next_tx;
      end
   end

   // ***************************************************************
   // Start triggers and serial clock events
   // ***************************************************************
   logic tx_start, rx_start, start, half_tick, ev, lead, fin;
   logic [15:0] shifted;

   // Writes or reads during a transfer never start another one
   assign tx_start = wr_tx & pwr & txe & ~tsf;
   assign rx_start = rd_rx & pwr & rxe & ~txe & sce & ~tsf;
   assign start = ce & (tx_start | rx_start);

   pin_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pins({serial_clock_in, serial_data_in_pin}),
      .synced(synced)
   );

   half_tick_div u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .run(tsf & ~slave),
      .clock_source(clock_mode_reg[2:0]),
      .baud_tick(baud_generator_output),
      .half_tick(half_tick)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_prev <= 1'b0;
      end else if (ce) begin
         sck_prev <= sck_s;
      end
   end

   assign ev = slave ? (sck_s ^ sck_prev) : half_tick;
   assign lead = slave ? (sck_s != sck_idle) : (sck_level == sck_idle);
   assign shifted = shift_in(shifter, dap ? held_rx : din_s, code, dir);
   assign fin = ce & pwr & tsf & ev & ~lead & ((bits_done + 5'h1) == len_bits(code));

   // ***************************************************************
   // Transfer engine
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xfer_state <= ST_IDLE;
         shifter <= 16'h0;
         bits_done <= 5'h0;
         sck_level <= 1'b1;
         out_bit <= 1'b0;
         held_rx <= 1'b0;
      end else if (ce) begin
         if (!pwr) begin
            xfer_state <= ST_IDLE;
            bits_done <= 5'h0;
            sck_level <= sck_idle;
            out_bit <= 1'b0;
         end else begin
            case (xfer_state)
               ST_IDLE: begin
                  sck_level <= sck_idle;
                  bits_done <= 5'h0;
                  if (start) begin
                     xfer_state <= ST_RUN;
                     shifter <= next_tx;
                     out_bit <= dap & txe & msb_of(next_tx, code, dir);
                  end else begin
                     out_bit <= 1'b0;
                  end
               end
               ST_RUN: begin
                  if (ev) begin
                     if (!slave) begin
                        sck_level <= ~sck_level;
                     end
                     if (lead) begin
                        held_rx <= din_s;
                        if (!dap) begin
                           out_bit <= txe & msb_of(shifter, code, dir);
                        end
                     end else begin
                        shifter <= shifted;
                        bits_done <= bits_done + 5'h1;
                        if (fin) begin
                           // Data holds through the last sampling edge, idle drops it
                           xfer_state <= ST_IDLE;
                        end else if (dap) begin
                           out_bit <= txe & msb_of(shifted, code, dir);
                        end
                     end
                  end
               end
               default: xfer_state <= ST_IDLE;
            endcase
         end
      end
   end

   assign serial_clock_out = sck_level;
   assign serial_clock_oe_n = ~(pwr & ~slave);
   assign serial_data_out_pin = out_bit;

   // ***************************************************************
   // Receive register, overrun and interrupt requests
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_register <= 16'h0;
      end else if (fin && rxe) begin
         receive_register <= shifted & len_mask(code);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_unread <= 1'b0;
      end else if (ce) begin
         if (!pwr) begin
            rx_unread <= 1'b0;
         end else if (fin) begin
            rx_unread <= 1'b1;
         end else if (rd_rx) begin
            rx_unread <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overrun_flag <= 1'b0;
      end else if (ce) begin
         if (!pwr) begin
            overrun_flag <= 1'b0;
         end else if (fin && rx_unread && !rd_rx) begin
            overrun_flag <= 1'b1;
         end else if (wr_status && !w_data[ST_OVE]) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   // Reception complete has the higher priority in the interrupt controller
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reception_complete_irq <= 1'b0;
         transmission_enable_irq <= 1'b0;
      end else if (ce) begin
         reception_complete_irq <= fin & (rxe | ~tms);
         transmission_enable_irq <= start & tms & txe;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_tx_start;
      wr_tx && pwr && txe && !tsf;
   endsequence
   sequence s_rx_start;
      rd_rx && pwr && rxe && !txe && sce && !tsf;
   endsequence
   sequence s_finish;
      fin;
   endsequence

   property p_tx_sets_tsf;
      @(posedge aclk) disable iff (!aresetn) s_tx_start |=> tsf ##0 (shifter == $past(next_tx));
   endproperty
   a_tx_sets_tsf: assert property (p_tx_sets_tsf) else $error("transmit write did not start");

   property p_rx_sets_tsf;
      @(posedge aclk) disable iff (!aresetn) s_rx_start |=> tsf;
   endproperty
   a_rx_sets_tsf: assert property (p_rx_sets_tsf) else $error("dummy read did not start");

   property p_no_trigger;
      @(posedge aclk) disable iff (!aresetn) rd_rx && !sce && !tsf && !wr_tx |=> !tsf;
   endproperty
   a_no_trigger: assert property (p_no_trigger) else $error("read started without trigger");

   property p_finish_ends;
      @(posedge aclk) disable iff (!aresetn)
         s_finish |=> !tsf && (serial_clock_out == sck_idle) ##1 (tsf || !out_bit);
   endproperty
   a_finish_ends: assert property (p_finish_ends) else $error("word end did not stop");

   property p_irq_single;
      @(posedge aclk) disable iff (!aresetn) s_finish ##0 !tms |=> reception_complete_irq;
   endproperty
   a_irq_single: assert property (p_irq_single) else $error("no completion request");

   property p_irq_cause;
      @(posedge aclk) disable iff (!aresetn) reception_complete_irq && $past(ce) |-> $past(fin);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("spurious completion request");

   property p_rx_upper;
      @(posedge aclk) disable iff (!aresetn) s_finish ##0 rxe |=> (receive_register & ~len_mask(code)) == 16'h0;
   endproperty
   a_rx_upper: assert property (p_rx_upper) else $error("upper receive bits not zero");

   property p_overrun_set;
      @(posedge aclk) disable iff (!aresetn) s_finish ##0 (rx_unread && !rd_rx) |=> overrun_flag;
   endproperty
   a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

   property p_overrun_w1;
      @(posedge aclk) disable iff (!aresetn) wr_status && w_data[ST_OVE] && !fin |=> $stable(overrun_flag);
   endproperty
   a_overrun_w1: assert property (p_overrun_w1) else $error("writing one changed overrun");

   property p_power_off;
      @(posedge aclk) disable iff (!aresetn) ce && !pwr |=> !tsf && !overrun_flag;
   endproperty
   a_power_off: assert property (p_power_off) else $error("status not cleared at power off");

   property p_sout_low;
      @(posedge aclk) disable iff (!aresetn) ce && !txe |=> !serial_data_out_pin;
   endproperty
   a_sout_low: assert property (p_sout_low) else $error("data out high while disabled");

   property p_tei_single;
      @(posedge aclk) disable iff (!aresetn) ce && !tms |=> !transmission_enable_irq;
   endproperty
   a_tei_single: assert property (p_tei_single) else $error("transmit request in single mode");

   property p_master_drive;
      @(posedge aclk) disable iff (!aresetn) tsf && !slave |-> !serial_clock_oe_n;
   endproperty
   a_master_drive: assert property (p_master_drive) else $error("master not driving clock");
endmodule

/* File: bench/serial_peer.sv */
// Behavioural serial slave at the far side of the link
`timescale 1ns/1ps
module serial_peer (
   input wire logic aclk,
   input wire logic sck,
   input wire logic sdo,
   input wire logic arm,
   input wire logic [15:0] word,
   output logic sdi,
   output logic [15:0] rx
);
   logic [15:0] sh = 16'h0;
   logic sck_d = 1'b1;
   // Type 1: next bit one clock after the falling edge, capture on the rising one
   always @(posedge aclk) begin
      sck_d <= sck;
      if (arm) begin
         sh <= word;
         sdi <= 1'b0;
      end else if (sck_d && !sck) begin
         sdi <= sh[15];
         sh <= sh << 1;
      end
   end
   always @(posedge sck) begin
      rx <= {rx[14:0], sdo};
   end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the clocked serial channel
`timescale 1ns/1ps
module tb;
   import csib_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, arm = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic [15:0] peer_word = 16'h0, peer_rx;
   logic awready, wready, bvalid, arready, rvalid, sck_out, sck_oe_n, sdo, sdi, irq_r, te_irq;
   logic [1:0] bresp, resp, rresp;
   int failures = 0, tests_run = 0;
   int te_count = 0;
   // Clock pin has a pull-up while nobody drives it
   wire sck_line = sck_oe_n ? 1'b1 : sck_out;
   always #4 aclk = ~aclk;
   always @(posedge aclk) te_count <= te_count + (te_irq === 1'b1);
   clocked_serial_channel i_clocked_serial_channel (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .baud_generator_output(1'b0), .serial_clock_in(sck_line),
      .serial_clock_out(sck_out), .serial_clock_oe_n(sck_oe_n), .serial_data_out_pin(sdo),
      .serial_data_in_pin(sdi), .reception_complete_irq(irq_r), .transmission_enable_irq(te_irq));
   serial_peer i_serial_peer (.aclk(aclk), .sck(sck_line), .sdo(sdo), .arm(arm), .word(peer_word),
      .sdi(sdi), .rx(peer_rx));
   task automatic finish_test(input bit to);
      failures += to;
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [29:0] idx, input logic [31:0] d);
      int n;
      bit done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         done = bvalid;
      end
      resp = bresp;
      bready <= 1'b0;
      if (!done) finish_test(1'b1);
   endtask
   task automatic rd(input logic [29:0] idx, output logic [31:0] d);
      int n;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n == 50) finish_test(1'b1);
   endtask
   task automatic wait_done();
      int n;
      for (n = 0; n < 500; n++) begin
         @(posedge aclk);
         if (irq_r === 1'b1) break;
      end
      if (n == 500) finish_test(1'b1);
   endtask
   // One master word: transmit write or receive dummy read, then completion
   task automatic xfer(input int len, input logic [15:0] txd, input logic [15:0] pd, input bit rxo);
      logic [31:0] v;
      logic [15:0] m;
      m = 16'hffff >> (16 - len);
      peer_word <= pd << (16 - len);
      arm <= 1'b1;
      @(posedge aclk);
      arm <= 1'b0;
      if (rxo) rd(IDX_RX, v);
      else wr(IDX_TX, {16'h0, txd});
      rd(IDX_STATUS, v);
      chk(v, 32'h80);
      wait_done();
      rd(IDX_STATUS, v);
      chk(v[7], 1'b0);
      if (!rxo) chk(peer_rx & m, txd & m);
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial begin
      logic [31:0] v;
      int i;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_STATUS, v);
      chk(v, 32'h0);
      chk(resp, RESP_OKAY);
      rd(IDX_LENGTH, v);
      chk(v, 32'h0);
      wr(30'h0, 32'h1);
      chk(resp, RESP_SLVERR);
      rd(30'h0, v);
      chk(resp, RESP_SLVERR);
      chk(v, 32'h0);
      // Transfer clock fxx/16, the fastest one at or below the limit
      wr(IDX_CLKMODE, 32'h3);
      wr(IDX_LENGTH, 32'h0);
      wr(IDX_MAIN, 32'he1);
      xfer(8, 16'h12a5, 16'h3c, 1'b0);
      rd(IDX_RX, v);
      chk(v, 32'h3c);
      xfer(8, 16'h5a, 16'hc3, 1'b0);
      xfer(8, 16'h0f, 16'h81, 1'b0);
      rd(IDX_STATUS, v);
      chk(v, 32'h1);
      wr(IDX_STATUS, 32'h81);
      rd(IDX_STATUS, v);
      chk(v, 32'h1);
      wr(IDX_MAIN, 32'h0);
      rd(IDX_STATUS, v);
      chk(v, 32'h0);
      wr(IDX_LENGTH, 32'h4);
      wr(IDX_MAIN, 32'he1);
      xfer(12, 16'hfabc, 16'h123, 1'b0);
      rd(IDX_RX, v);
      chk(v, 32'h123);
      wr(IDX_MAIN, 32'h0);
      wr(IDX_LENGTH, 32'hc);
      wr(IDX_MAIN, 32'he1);
      for (i = 0; i < 2; i++) xfer(16, 16'hbeef, 16'h1357, 1'b0);
      wr(IDX_STATUS, 32'h80);
      rd(IDX_STATUS, v);
      chk(v, 32'h0);
      wr(IDX_MAIN, 32'h0);
      wr(IDX_MAIN, 32'ha1);
      xfer(16, 16'h0, 16'h2468, 1'b1);
      chk(sdo, 1'b0);
      rd(IDX_RX, v);
      chk(v, 32'h2468);
      rd(IDX_STATUS, v);
      chk(v, 32'h80);
      wait_done();
      wr(IDX_MAIN, 32'ha0);
      rd(IDX_RX, v);
      rd(IDX_STATUS, v);
      chk(v, 32'h0);
      // LSB-first reception: the last bit on the line lands in bit 15
      wr(IDX_MAIN, 32'h0);
      wr(IDX_MAIN, 32'hb1);
      xfer(16, 16'h0, 16'h1, 1'b1);
      wr(IDX_MAIN, 32'hb0);
      rd(IDX_RX, v);
      chk(v, 32'h8000);
      // Continuous mode: transmit start raises the transmission enable request
      wr(IDX_MAIN, 32'h0);
      chk(te_count, 0);
      wr(IDX_MAIN, 32'he3);
      wr(IDX_TX, 32'h55);
      wait_done();
      chk(te_count, 1);
      wr(IDX_MAIN, 32'h0);
      finish_test(1'b0);
   end
endmodule
